// ---- rtl/supply_level_detector_defines.svh ----
// Offsets, field positions, reset values and timing counts of the supply level detector
`ifndef SUPPLY_LEVEL_DETECTOR_DEFINES_SVH
`define SUPPLY_LEVEL_DETECTOR_DEFINES_SVH

// Register offsets on the plain port
`define SLD_OFS_CONTROL 4'h0
`define SLD_OFS_FLAGS 4'h1
`define SLD_OFS_ENABLES 4'h2
`define SLD_OFS_PRIOR 4'h3
`define SLD_OFS_CORE 4'h4

// Control register fields
`define SLD_LIMIT_LSB 0
`define SLD_LIMIT_MSB 3
`define SLD_POWER_BIT 4
`define SLD_STABLE_BIT 5
`define SLD_DIR_BIT 7
`define SLD_LIMIT_EXTERNAL 4'hf

// Event bit position in flags, enables and priorities
`define SLD_EVENT_BIT 2
// Global enable position in core interrupt control
`define SLD_GLOBAL_BIT 7

// Reset values
`define SLD_CONTROL_RST 8'h05
`define SLD_ZERO_RST 8'h00

// Reference settling time in ns and clock period in ns
`define SLD_SETTLE_NS 20000
`define SLD_CLK_NS 8
`define SLD_SETTLE_CYC ((`SLD_SETTLE_NS + `SLD_CLK_NS - 1) / `SLD_CLK_NS)

`endif

// ---- rtl/supply_level_detector_pkg.sv ----
// Types shared by the supply level detector
package supply_level_detector_pkg;

   // Register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   // Settling sequencer states
   typedef enum logic [2:0] {
      OFF = 3'b001,
      SETTLING = 3'b010,
      STABLE = 3'b100
   } settle_state_t;

   // Whole module state
   typedef struct packed {
      logic [7:0] control;
      logic [7:0] flags;
      logic [7:0] enables;
      logic [7:0] prior;
      logic [7:0] core;
      logic [7:0] rdata;
      settle_state_t state;
      logic [31:0] settleCnt;
      logic [1:0] cmpSync;
      logic [1:0] doneSync;
      logic wake;
   } state_t;

endpackage

// ---- rtl/supply_level_detector.sv ----
// Digital control around the supply voltage level detector
// Operation
// - Trip crossing sets voltage event flag
// - Four-bit limit field selects trip point
// - Limit all ones selects external input
// - Direction one rise, zero fall
// - Interrupt needs detector and global enable
// - No interrupt before reference stable bit
// - Flag inhibited during clock-independent settling
// - Enable powers comparator and divider
// - Flag resets if condition still holds
// - Detector runs in sleep, wakes device
// - Vector taken only if globally enabled
// - Reset returns registers, detector off
// - Stable bit read-only, shows settled
// - Direction selects drop or rise watch
//
// The implementer's own choices: strobed register access and the register offsets.
`include "supply_level_detector_defines.svh"

module supply_level_detector #(
   parameter int unsigned SETTLE_CYCLES = `SLD_SETTLE_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   // Analog front end
   input wire logic comparatorOut,
   input wire logic settleDone,
   output logic detectorPower,
   output logic [3:0] tripLimitSelect,
   output logic externalTripInput,
   output logic detectDirection,
   // Core side
   input wire logic sleeping,
   output logic interruptRequest,
   output logic highPriority,
   output logic wakeRequest,
   output logic vectorTaken
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (SETTLE_CYCLES < 1) begin : gBadSettle
      $error("SETTLE_CYCLES must be at least one");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   supply_level_detector_pkg::state_t s_q;
   supply_level_detector_pkg::state_t s_d;
   supply_level_detector_pkg::reg_req_t req;
   logic powerOn;
   logic condition;
   logic stable;
   logic flagClear;

   // Decode a register write at one offset
   function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs, input logic st);
      hit = st && (a == ofs);
   endfunction

   // Request carrier
   assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

   // Trip condition from synchronised comparator alone; direction is applied in the analog front end
   assign powerOn = s_q.control[`SLD_POWER_BIT];
   assign stable = (s_q.state == supply_level_detector_pkg::STABLE);
   assign condition = s_q.cmpSync[1];
   assign flagClear = hit(req.addr, `SLD_OFS_FLAGS, req.wr)
                      && !req.wdata[`SLD_EVENT_BIT];

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // Two-stage synchronisers for analog outputs
      s_d.cmpSync = {s_q.cmpSync[0], comparatorOut};
      s_d.doneSync = {s_q.doneSync[0], settleDone};

      // Register writes
      if (hit(req.addr, `SLD_OFS_CONTROL, req.wr)) begin
         s_d.control[`SLD_LIMIT_MSB:`SLD_LIMIT_LSB] =
            req.wdata[`SLD_LIMIT_MSB:`SLD_LIMIT_LSB];
         s_d.control[`SLD_POWER_BIT] = req.wdata[`SLD_POWER_BIT];
         s_d.control[`SLD_DIR_BIT] = req.wdata[`SLD_DIR_BIT];
      end
      if (hit(req.addr, `SLD_OFS_FLAGS, req.wr)) begin
         s_d.flags = req.wdata;
      end
      if (hit(req.addr, `SLD_OFS_ENABLES, req.wr)) begin
         s_d.enables = req.wdata;
      end
      if (hit(req.addr, `SLD_OFS_PRIOR, req.wr)) begin
         s_d.prior = req.wdata;
      end
      if (hit(req.addr, `SLD_OFS_CORE, req.wr)) begin
         s_d.core = req.wdata;
      end

      // Settling sequencer
      unique case (s_q.state)
         supply_level_detector_pkg::OFF: begin
            s_d.settleCnt = '0;
            if (s_d.control[`SLD_POWER_BIT]) begin
               s_d.state = supply_level_detector_pkg::SETTLING;
            end
         end
         supply_level_detector_pkg::SETTLING: begin
            s_d.settleCnt = s_q.settleCnt + 32'h0000_0001;
            if (!s_d.control[`SLD_POWER_BIT]) begin
               s_d.state = supply_level_detector_pkg::OFF;
            end else if (s_q.settleCnt >= 32'(SETTLE_CYCLES - 1) && s_q.doneSync[1]) begin
               s_d.state = supply_level_detector_pkg::STABLE;
            end
         end
         supply_level_detector_pkg::STABLE: begin
            if (!s_d.control[`SLD_POWER_BIT]) begin
               s_d.state = supply_level_detector_pkg::OFF;
            end
         end
         default: s_d.state = supply_level_detector_pkg::OFF;
      endcase

      // Stable bit is read-only and mirrors the sequencer
      s_d.control[`SLD_STABLE_BIT] = (s_d.state == supply_level_detector_pkg::STABLE);
      s_d.control[6] = 1'b0;

      // Event sets flag, set wins over clear, re-sets while held
      if (stable && powerOn && condition) begin
         s_d.flags[`SLD_EVENT_BIT] = 1'b1;
      end else if (flagClear) begin
         s_d.flags[`SLD_EVENT_BIT] = 1'b0;
      end

      // Wake pulse on flag rising while asleep
      s_d.wake = sleeping && s_d.flags[`SLD_EVENT_BIT]
                 && !s_q.flags[`SLD_EVENT_BIT];

      // Read data one cycle later
      s_d.rdata = 8'h00;
      if (req.rd) begin
         unique case (req.addr)
            `SLD_OFS_CONTROL: s_d.rdata = s_q.control;
            `SLD_OFS_FLAGS: s_d.rdata = s_q.flags;
            `SLD_OFS_ENABLES: s_d.rdata = s_q.enables;
            `SLD_OFS_PRIOR: s_d.rdata = s_q.prior;
            `SLD_OFS_CORE: s_d.rdata = s_q.core;
            default: s_d.rdata = 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s_q.control <= `SLD_CONTROL_RST;
         s_q.flags <= `SLD_ZERO_RST;
         s_q.enables <= `SLD_ZERO_RST;
         s_q.prior <= `SLD_ZERO_RST;
         s_q.core <= `SLD_ZERO_RST;
         s_q.rdata <= 8'h00;
         s_q.state <= supply_level_detector_pkg::OFF;
         s_q.settleCnt <= 32'h0000_0000;
         s_q.cmpSync <= 2'b00;
         s_q.doneSync <= 2'b00;
         s_q.wake <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign regRdata = s_q.rdata;
   assign detectorPower = powerOn;
   assign tripLimitSelect = s_q.control[`SLD_LIMIT_MSB:`SLD_LIMIT_LSB];
   assign externalTripInput = powerOn
      && (tripLimitSelect == `SLD_LIMIT_EXTERNAL);
   assign detectDirection = s_q.control[`SLD_DIR_BIT];
   // Level interrupt gated by detector and global enable
   assign interruptRequest = s_q.flags[`SLD_EVENT_BIT] && s_q.enables[`SLD_EVENT_BIT]
                             && s_q.core[`SLD_GLOBAL_BIT];
   assign highPriority = interruptRequest && s_q.prior[`SLD_EVENT_BIT];
   assign wakeRequest = s_q.wake;
   assign vectorTaken = s_q.wake && s_q.core[`SLD_GLOBAL_BIT];

endmodule // supply_level_detector

// ---- testbench/supply_level_detector_properties.sv ----
// Assertions on the supply level detector ports
module supply_level_detector_properties (
   // Clock, reset, register port
   input wire logic mclk, reset, regWr, regRd,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata, regRdata,
   // Detector and core side
   input wire logic detectorPower, externalTripInput, detectDirection,
   input wire logic [3:0] tripLimitSelect,
   input wire logic interruptRequest, highPriority, wakeRequest, vectorTaken
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // Write to the control register
   wire ctlWr = regWr && regAddr == 4'h0;
   property p_power; ctlWr |=> detectorPower == $past(regWdata[4]); endproperty
   a_power: assert property (p_power) else $error("power bit lost");
   property p_limit; ctlWr |=> tripLimitSelect == $past(regWdata[3:0]); endproperty
   a_limit: assert property (p_limit) else $error("limit lost");
   property p_dir; ctlWr |=> detectDirection == $past(regWdata[7]); endproperty
   a_dir: assert property (p_dir) else $error("direction lost");
   property p_ext; ctlWr |=> externalTripInput == ($past(regWdata[4:0]) == 5'h1f); endproperty
   a_ext: assert property (p_ext) else $error("external select wrong");
   property p_prio; highPriority |-> interruptRequest; endproperty
   a_prio: assert property (p_prio) else $error("priority without request");
   property p_vec; vectorTaken |-> wakeRequest; endproperty
   a_vec: assert property (p_vec) else $error("vector without wake");
   property p_wake; wakeRequest |=> !wakeRequest; endproperty
   a_wake: assert property (p_wake) else $error("wake not a pulse");
   property p_stable; regRd && regAddr == 4'h0 && !detectorPower |=> !regRdata[5]; endproperty
   a_stable: assert property (p_stable) else $error("stable while off");
   // Main scenarios
   c_irq: cover property (interruptRequest);
   c_wake: cover property (wakeRequest);
   c_ext: cover property (externalTripInput);
endmodule // supply_level_detector_properties

bind supply_level_detector supply_level_detector_properties properties_inst (.mclk, .reset,
   .regWr, .regRd, .regAddr, .regWdata, .regRdata, .detectorPower, .externalTripInput,
   .detectDirection, .tripLimitSelect, .interruptRequest, .highPriority, .wakeRequest,
   .vectorTaken);

// ---- testbench/analog_front_end.sv ----
// Behavioural comparator, reference and divider
module analog_front_end (
   // Digital controls
   input wire logic detectorPower, externalTripInput, detectDirection,
   input wire logic [3:0] tripLimitSelect,
   // Levels set by the bench
   input wire logic [3:0] supplyLevel, pinLevel,
   // Towards the block
   output logic comparatorOut, settleDone
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] sensed, trip;
   // Pin against a fixed reference in external mode
   assign sensed = externalTripInput ? pinLevel : supplyLevel;
   assign trip = externalTripInput ? 4'h8 : tripLimitSelect;
   // Unpowered comparator stays low
   assign comparatorOut = detectorPower &&
      (detectDirection ? sensed >= trip : sensed <= trip);
   // Fixed settling time, whatever the clock
   always @(detectorPower) settleDone <= #200 detectorPower;
endmodule // analog_front_end

// ---- testbench/testbench.sv ----
// Self-checking bench for the supply level detector
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, reset = 1'b1, regWr = 1'b0, regRd = 1'b0, sleeping = 1'b0;
   logic [3:0] regAddr = 4'h0, supplyLevel = 4'h9, pinLevel = 4'h0, tripLimitSelect;
   logic [7:0] regWdata = 8'h00, regRdata;
   logic comparatorOut, settleDone, detectorPower, externalTripInput, detectDirection;
   logic interruptRequest, highPriority, wakeRequest, vectorTaken;
   int n_errors = 0, samples_checked = 0;
   // Block and its analog side
   supply_level_detector #(.SETTLE_CYCLES(4)) supply_level_detector_inst (.mclk, .reset,
      .regAddr, .regWdata, .regWr, .regRd, .regRdata, .comparatorOut, .settleDone,
      .detectorPower, .tripLimitSelect, .externalTripInput, .detectDirection, .sleeping,
      .interruptRequest, .highPriority, .wakeRequest, .vectorTaken);
   analog_front_end analog_front_end_inst (.detectorPower, .externalTripInput,
      .detectDirection, .tripLimitSelect, .supplyLevel, .pinLevel, .comparatorOut,
      .settleDone);
   // 125 MHz clock
   initial forever #4 mclk = ~mclk;
   task automatic chk(input logic [7:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask
   // Write strobe for one cycle, then wait to the falling edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
      @(negedge mclk);
   endtask
   // Read data judged in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 chk(regRdata, exp);
   endtask
   task automatic t_reset();
      for (int a = 0; a < 6; a++) rd(4'(a), a == 0 ? 8'h05 : 8'h00);
      wr(4'h0, 8'h65);
      rd(4'h0, 8'h05);
   endtask
   task automatic t_rise();
      wr(4'h0, 8'h03);
      wr(4'h0, 8'h83);
      wr(4'h0, 8'h93);
      wr(4'h1, 8'h00);
      wr(4'h2, 8'h04);
      wr(4'h4, 8'h80);
      rd(4'h1, 8'h00);
      rd(4'h0, 8'h93);
      for (int i = 0; i < 80 && interruptRequest !== 1'b1; i++) @(negedge mclk);
      chkb(interruptRequest, 1'b1);
      rd(4'h0, 8'hb3);
   endtask
   task automatic t_hold();
      wr(4'h1, 8'h00);
      rd(4'h1, 8'h04);
      wr(4'h3, 8'h04);
      chkb(highPriority, 1'b1);
      wr(4'h4, 8'h00);
      chkb(interruptRequest, 1'b0);
      wr(4'h4, 8'h80);
      wr(4'h2, 8'h00);
      chkb(interruptRequest, 1'b0);
      wr(4'h2, 8'h04);
   endtask
   task automatic t_sleep();
      wr(4'h0, 8'h13);
      @(posedge mclk);
      sleeping <= 1'b1;
      repeat (4) @(posedge mclk);
      wr(4'h1, 8'h00);
      rd(4'h1, 8'h00);
      supplyLevel <= 4'h2;
      for (int i = 0; i < 20 && wakeRequest !== 1'b1; i++) @(negedge mclk);
      chkb(vectorTaken, 1'b1);
      rd(4'h1, 8'h04);
      @(posedge mclk);
      sleeping <= 1'b0;
   endtask
   task automatic t_ext();
      wr(4'h0, 8'h1f);
      chkb(externalTripInput, 1'b1);
      for (int c = 0; c < 16; c++) begin
         wr(4'h0, 8'(c));
         chk({4'h0, tripLimitSelect}, 8'(c));
      end
      chkb(detectorPower, 1'b0);
      chkb(externalTripInput, 1'b0);
      rd(4'h0, 8'h0f);
   endtask
   task automatic end_of_test();
      $display("checked %0d, errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Reset, then the scenarios in turn
   initial begin
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      t_reset();
      t_rise();
      t_hold();
      t_sleep();
      t_ext();
      end_of_test();
   end
   // Watchdog far beyond the expected run of about one microsecond
   initial begin
      #40000;
      n_errors++;
      end_of_test();
   end
endmodule // testbench
